// *** rtl/status_gpio_defines.svh ***
// Register offsets, field positions, reset values and one-time memory contents
`ifndef STATUS_GPIO_DEFINES_SVH
`define STATUS_GPIO_DEFINES_SVH
// Register byte offsets
`define REG_CTRL 8'h00
`define REG_GPO 8'h04
`define REG_GPI 8'h08
`define REG_STATUS 8'h0C
`define REG_IRQ_EN 8'h10
`define REG_OUT_CTRL 8'h14
`define REG_OE_MAP 8'h18
`define REG_BOOT 8'h1C
// Control register fields
`define CTRL_DIR 3:0
`define CTRL_FIXED 7:4
`define CTRL_DIR_MAPSEL 1:0
`define CTRL_FIXED_MAPSEL 5:4
`define CTRL_DIR_REFSEL 2
`define CTRL_FIXED_REFSEL 6
`define CTRL_LOL_MODE 8
`define CTRL_EXT_BOOT 9
`define CTRL_OTP_REST 10
`define CTRL_WIDTH 11
`define CTRL_RESET 11'h0F0
// Output control fields
`define OUTC_PD 3:0
`define OUTC_EN 7:4
// Status register fields
`define STAT_FLAGS 3:0
`define STAT_IRQ 4
`define STAT_BOOT_FAILURE_FLAG 5
`define STAT_LIVE 11:8
// Flag bit positions
`define FLAG_LOL 0
`define FLAG_HOLD 1
`define FLAG_LOS0 2
`define FLAG_LOS1 3
// One-time memory contents: control, output control, maps, general outputs
`define OTP_CTRL 32'h0000_06F0
`define OTP_OUT_CTRL 32'h0000_00F0
`define OTP_OE_MAP 32'h0000_F31F
`define OTP_GPO 32'h0000_0000
// External boot: three data bytes then one checksum byte
`define EXT_LAST_IDX 2'h3
`define EXT_BASE 8'h00
`endif

// *** rtl/status_gpio_pkg.sv ***
// Types shared by the status, pin and start-up logic
package status_gpio_pkg;
    typedef enum logic [2:0] {st_reset, st_otp_init, st_decide, st_otp_rest, st_ext_boot, st_ready} boot_state_e;
endpackage

// *** rtl/status_gpio_irq_reset_ctrl.sv ***
// Status flags, general-purpose pins, output gating and start-up sequencing with an APB register port
//
// What this block does
// - Four general-purpose pins, each set as input or output.
// - Each pin works under register control or a fixed function.
// - Before the one-time load, pins are inputs: 1 and 0 select the output-enable map, 2 selects the reference.
// - Fixed outputs show live loss of lock, signal loss and holdover; fixed inputs select.
// - Loss-of-lock clears on lock, or only after lock and sync finish.
// - Sticky flags for loss of lock, holdover and each input signal loss.
// - A flag stays set until alarm gone and software writes one, or reset.
// - Each flag has an interrupt enable; all enables clear at reset.
// - Interrupt status and low interrupt pin assert when an enabled flag is set.
// - Host drives pins 1 and 0 to pick one of four enable maps.
// - Clock output on only if powered, register-enabled and map allows it.
// - Reset holds while power-on reset or master reset is asserted.
// - In reset all registers and state machines hold default values, except the alarm synchroniser, which only power-on reset clears.
// - In reset the register port ignores accesses and gives no answer.
// - In reset all clock outputs are off and pins are inputs, pins 1 and 0 selecting the enable map.
// - In reset status and enable bits clear, interrupt pin deasserted.
// - Self-configuration starts only after both resets have been released.
// - First load an initial block, then choose external, internal or both sources.
// - Register port answers only after configuration loading has ended, also when a boot read was refused.
// - With external boot enabled the block reads settings from external memory.
// - Register accesses are not answered while the external boot read runs.
// - Refused read or bad checksum sets boot failure; unloaded registers keep defaults.
`timescale 1ns/1ps
`default_nettype none
`include "status_gpio_defines.svh"

module status_gpio_irq_reset_ctrl
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic master_reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pll_locked,
    input wire logic sync_busy,
    input wire logic holdover_alarm,
    input wire logic [1:0] loss_of_signal,
    input wire logic [3:0] gpio_in,
    output logic [3:0] gpio_out,
    output logic [3:0] gpio_oe,
    output logic ref_select_in,
    output logic [3:0] clk_out_enable,
    output logic irq_out_n,
    output logic config_done,
    output logic ext_rd_req,
    output logic [7:0] ext_rd_addr,
    input wire logic ext_rd_done,
    input wire logic ext_rd_nack,
    input wire logic [7:0] ext_rd_data
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    localparam logic [31:0] otp_rom [0:3] = '{`OTP_CTRL, `OTP_OUT_CTRL, `OTP_OE_MAP, `OTP_GPO};

    status_gpio_pkg::boot_state_e state;
    logic [`CTRL_WIDTH-1:0] ctrl;
    logic [3:0] gp_output_bit;
    logic [3:0] irq_en;
    logic [7:0] out_ctrl;
    logic [15:0] oe_map;
    logic [3:0] flags;
    logic boot_failure_flag;
    logic [3:0] alarm_s1;
    logic [3:0] alarm_s2;
    logic [3:0] live;
    logic [3:0] gp_input_bit;
    logic [1:0] oe_map_select;
    logic [3:0] map_mask;
    logic map_used;
    logic [1:0] ext_idx;
    logic [7:0] ext_sum;
    logic apb_wr;
    logic apb_hit;
    logic [31:0] next_prdata;
    logic in_reset;
    logic ready;

    assign in_reset = !master_reset_n;
    assign ready = (state == status_gpio_pkg::st_ready);
    assign apb_wr = psel && penable && pwrite && pready;

    // ----------------------------------------
    // Alarm synchroniser and live alarm levels
    // ----------------------------------------
    // Two stages; only the second stage is used by logic
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            alarm_s1 <= 4'h0;
            alarm_s2 <= 4'h0;
        end
        else
        begin
            alarm_s1 <= {loss_of_signal, holdover_alarm, !pll_locked};
            alarm_s2 <= alarm_s1;
        end
    end

    // Loss of lock may be stretched until synchronisation has finished
    always_comb
    begin
        live = {alarm_s2[3:1], 1'b0};
        live[`FLAG_LOL] = alarm_s2[0] || (ctrl[`CTRL_LOL_MODE] && sync_busy);
    end

    // Pin inputs and map selection
    assign gp_input_bit = gpio_in & ~ctrl[`CTRL_DIR];
    assign oe_map_select = gpio_in[1:0];
    assign map_used = (ctrl[`CTRL_DIR_MAPSEL] == 2'h0) && (ctrl[`CTRL_FIXED_MAPSEL] == 2'h3);
    assign map_mask = oe_map[{oe_map_select, 2'h0} +: 4];

    // ----------------------------------------
    // Start-up sequencer
    // ----------------------------------------
    // Reset, initial block, decision, remaining load, external boot, run
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= status_gpio_pkg::st_reset;
            ext_idx <= 2'h0;
            ext_sum <= 8'h00;
            ext_rd_req <= 1'b0;
            ext_rd_addr <= 8'h00;
        end
        else if (in_reset)
        begin
            state <= status_gpio_pkg::st_reset;
            ext_idx <= 2'h0;
            ext_sum <= 8'h00;
            ext_rd_req <= 1'b0;
            ext_rd_addr <= 8'h00;
        end
        else
        begin
            case (state)
                status_gpio_pkg::st_reset:
                    state <= status_gpio_pkg::st_otp_init;
                status_gpio_pkg::st_otp_init:
                    state <= status_gpio_pkg::st_decide;
                status_gpio_pkg::st_decide:
                begin
                    if (ctrl[`CTRL_OTP_REST] || !ctrl[`CTRL_EXT_BOOT])
                        state <= status_gpio_pkg::st_otp_rest;
                    else
                    begin
                        state <= status_gpio_pkg::st_ext_boot;
                        ext_rd_req <= 1'b1;
                        ext_rd_addr <= `EXT_BASE;
                    end
                end
                status_gpio_pkg::st_otp_rest:
                begin
                    if (ctrl[`CTRL_EXT_BOOT])
                    begin
                        state <= status_gpio_pkg::st_ext_boot;
                        ext_rd_req <= 1'b1;
                        ext_rd_addr <= `EXT_BASE;
                    end
                    else
                        state <= status_gpio_pkg::st_ready;
                end
                status_gpio_pkg::st_ext_boot:
                begin
                    if (ext_rd_nack)
                    begin
                        ext_rd_req <= 1'b0;
                        state <= status_gpio_pkg::st_ready;
                    end
                    else if (ext_rd_done)
                    begin
                        ext_sum <= ext_sum + ext_rd_data;
                        ext_idx <= ext_idx + 2'h1;
                        ext_rd_addr <= ext_rd_addr + 8'h01;
                        if (ext_idx == `EXT_LAST_IDX)
                        begin
                            ext_rd_req <= 1'b0;
                            state <= status_gpio_pkg::st_ready;
                        end
                    end
                end
                default:
                    state <= status_gpio_pkg::st_ready;
            endcase
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    // Control: pin direction, fixed function, loss-of-lock mode, boot source
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= `CTRL_RESET;
        else if (in_reset)
            ctrl <= `CTRL_RESET;
        else if (state == status_gpio_pkg::st_otp_init)
            ctrl <= otp_rom[0][`CTRL_WIDTH-1:0];
        else if (apb_wr && paddr == `REG_CTRL)
            ctrl <= pwdata[`CTRL_WIDTH-1:0];
    end

    // General-purpose output bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gp_output_bit <= 4'h0;
        else if (in_reset)
            gp_output_bit <= 4'h0;
        else if (state == status_gpio_pkg::st_otp_rest)
            gp_output_bit <= otp_rom[3][3:0];
        else if (apb_wr && paddr == `REG_GPO)
            gp_output_bit <= pwdata[3:0];
    end

    // Output power-down, enables and enable maps; also loaded by external boot bytes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_ctrl <= 8'h00;
            oe_map <= 16'h0000;
        end
        else if (in_reset)
        begin
            out_ctrl <= 8'h00;
            oe_map <= 16'h0000;
        end
        else if (state == status_gpio_pkg::st_otp_rest)
        begin
            out_ctrl <= otp_rom[1][7:0];
            oe_map <= otp_rom[2][15:0];
        end
        else if (state == status_gpio_pkg::st_ext_boot)
        begin
            if (ext_rd_done && !ext_rd_nack)
            begin
                // Bytes already taken stay loaded even if a later read fails
                if (ext_idx == 2'h0)
                    out_ctrl <= ext_rd_data;
                else if (ext_idx == 2'h1)
                    oe_map[7:0] <= ext_rd_data;
                else if (ext_idx == 2'h2)
                    oe_map[15:8] <= ext_rd_data;
            end
        end
        else if (apb_wr && paddr == `REG_OUT_CTRL)
            out_ctrl <= pwdata[7:0];
        else if (apb_wr && paddr == `REG_OE_MAP)
            oe_map <= pwdata[15:0];
    end

    // Interrupt enables
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_en <= 4'h0;
        else if (in_reset)
            irq_en <= 4'h0;
        else if (apb_wr && paddr == `REG_IRQ_EN)
            irq_en <= pwdata[3:0];
    end

    // ----------------------------------------
    // Sticky flags
    // ----------------------------------------
    // A live alarm always wins over a write of one
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags <= 4'h0;
            boot_failure_flag <= 1'b0;
        end
        else if (in_reset)
        begin
            flags <= 4'h0;
            boot_failure_flag <= 1'b0;
        end
        else
        begin
            if (apb_wr && paddr == `REG_STATUS)
                flags <= live | (flags & ~pwdata[`STAT_FLAGS]);
            else
                flags <= live | flags;
            if (state == status_gpio_pkg::st_ext_boot && ext_rd_nack)
                boot_failure_flag <= 1'b1;
            else if (state == status_gpio_pkg::st_ext_boot && ext_rd_done && ext_idx == `EXT_LAST_IDX
                     && ext_sum != ext_rd_data)
                boot_failure_flag <= 1'b1;
            else if (apb_wr && paddr == `REG_STATUS && pwdata[`STAT_BOOT_FAILURE_FLAG])
                boot_failure_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // Pins, clock gating and interrupt pin
    // ----------------------------------------
    // All outputs registered; reset forces inputs, gated clocks, quiet interrupt
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gpio_out <= 4'h0;
            gpio_oe <= 4'h0;
            ref_select_in <= 1'b0;
            clk_out_enable <= 4'h0;
            irq_out_n <= 1'b1;
            config_done <= 1'b0;
        end
        else if (in_reset)
        begin
            gpio_out <= 4'h0;
            gpio_oe <= 4'h0;
            ref_select_in <= 1'b0;
            clk_out_enable <= 4'h0;
            irq_out_n <= 1'b1;
            config_done <= 1'b0;
        end
        else
        begin
            gpio_oe <= ctrl[`CTRL_DIR];
            // Fixed outputs: 3 loss of lock, 2 and 1 signal loss, 0 holdover
            gpio_out <= ctrl[`CTRL_FIXED] & {live[`FLAG_LOL], live[`FLAG_LOS0], live[`FLAG_LOS1], live[`FLAG_HOLD]}
                      | ~ctrl[`CTRL_FIXED] & gp_output_bit;
            ref_select_in <= ctrl[`CTRL_FIXED_REFSEL] && !ctrl[`CTRL_DIR_REFSEL] && gpio_in[2];
            clk_out_enable <= {4{ready}} & ~out_ctrl[`OUTC_PD] & out_ctrl[`OUTC_EN]
                            & (map_used ? map_mask : 4'hF);
            irq_out_n <= !(|(flags & irq_en));
            config_done <= ready;
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // Read data multiplexer
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        apb_hit = 1'b1;
        if (paddr == `REG_CTRL)
            next_prdata[`CTRL_WIDTH-1:0] = ctrl;
        else if (paddr == `REG_GPO)
            next_prdata[3:0] = gp_output_bit;
        else if (paddr == `REG_GPI)
            next_prdata[3:0] = gp_input_bit;
        else if (paddr == `REG_STATUS)
        begin
            next_prdata[`STAT_FLAGS] = flags;
            next_prdata[`STAT_IRQ] = |(flags & irq_en);
            next_prdata[`STAT_BOOT_FAILURE_FLAG] = boot_failure_flag;
            next_prdata[`STAT_LIVE] = live;
        end
        else if (paddr == `REG_IRQ_EN)
            next_prdata[3:0] = irq_en;
        else if (paddr == `REG_OUT_CTRL)
            next_prdata[7:0] = out_ctrl;
        else if (paddr == `REG_OE_MAP)
            next_prdata[15:0] = oe_map;
        else if (paddr == `REG_BOOT)
            next_prdata[3:0] = {ready, state};
        else
            apb_hit = 1'b0;
    end

    // Answer one cycle after select; no answer at all until configured
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (in_reset || !ready)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel && !pready;
            pslverr <= psel && !pready && !apb_hit;
            prdata <= (psel && !pready && !pwrite) ? next_prdata : 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    chk_irq_pin_level: assert property (@(posedge pclk) disable iff (!presetn)
        master_reset_n && $past(master_reset_n) |-> irq_out_n == !(|($past(flags) & $past(irq_en))))
        else $error("interrupt pin does not follow enabled flags");
    chk_clk_gate_off: assert property (@(posedge pclk) disable iff (!presetn)
        $past(out_ctrl[0]) || !$past(out_ctrl[4]) || !$past(ready) |-> !clk_out_enable[0])
        else $error("clock output 0 enabled against its gating");
    chk_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
        master_reset_n && live[`FLAG_HOLD] |=> flags[`FLAG_HOLD] || !master_reset_n)
        else $error("holdover flag not set by live alarm");
    chk_flag_sticks: assert property (@(posedge pclk) disable iff (!presetn)
        flags[0] && master_reset_n && !(apb_wr && paddr == `REG_STATUS) |=> flags[0] || !$past(master_reset_n))
        else $error("loss-of-lock flag cleared without a write");
    chk_reset_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        !master_reset_n |=> gpio_oe == 4'h0 && clk_out_enable == 4'h0 && irq_out_n && irq_en == 4'h0)
        else $error("reset did not force pins, clocks and enables");
    chk_no_answer_boot: assert property (@(posedge pclk) disable iff (!presetn)
        state != status_gpio_pkg::st_ready |=> !pready)
        else $error("register port answered before configuration");
    chk_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
        master_reset_n [*3] ##0 $rose(live[`FLAG_LOS0]) |-> $past(loss_of_signal[0], 2))
        else $error("signal loss used without two synchroniser stages");
    chk_boot_fail_nack: assert property (@(posedge pclk) disable iff (!presetn)
        master_reset_n && state == status_gpio_pkg::st_ext_boot && ext_rd_nack
        ##1 master_reset_n |-> boot_failure_flag && state == status_gpio_pkg::st_ready)
        else $error("refused boot read did not flag failure");
    chk_start_order: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(master_reset_n) && master_reset_n |-> state == status_gpio_pkg::st_reset ##1
        (state == status_gpio_pkg::st_otp_init || !master_reset_n))
        else $error("start-up did not wait for reset release");
    chk_fixed_lol: assert property (@(posedge pclk) disable iff (!presetn)
        master_reset_n && ctrl[7] |=> gpio_out[3] == $past(live[`FLAG_LOL]) || !master_reset_n)
        else $error("pin 3 does not show loss of lock");
    cov_ext_boot: cover property (@(posedge pclk) disable iff (!presetn)
        state == status_gpio_pkg::st_ext_boot ##1 state == status_gpio_pkg::st_ready);
    cov_irq_fire: cover property (@(posedge pclk) disable iff (!presetn) $fell(irq_out_n));
    cov_map_gate: cover property (@(posedge pclk) disable iff (!presetn) map_used && ready && map_mask != 4'hF);

endmodule
`default_nettype wire

// *** bench/ext_mem_model.sv ***
// Behavioural external boot memory that answers byte read requests
`timescale 1ns/1ps
`default_nettype none

module ext_mem_model
#(
    parameter int WAIT = 2
)
(
    input wire logic pclk,
    input wire logic nack_en,
    input wire logic ext_rd_req,
    input wire logic [7:0] ext_rd_addr,
    output logic ext_rd_done,
    output logic ext_rd_nack,
    output logic [7:0] ext_rd_data
);
    logic [7:0] mem [4];
    int cnt;

    // Three data bytes followed by their 8-bit sum
    initial
    begin
        mem[0] = 8'hF0;
        mem[1] = 8'h1F;
        mem[2] = 8'hF3;
        mem[3] = 8'h02;
        cnt = 0;
        ext_rd_done = 1'b0;
        ext_rd_nack = 1'b0;
        ext_rd_data = 8'h00;
    end

    // Answer after WAIT cycles, refused while nack_en; data toggles whenever not valid
    always @(posedge pclk)
    begin
        ext_rd_done <= 1'b0;
        ext_rd_nack <= 1'b0;
        ext_rd_data <= ~ext_rd_data;
        if (ext_rd_req && !ext_rd_done && !ext_rd_nack)
        begin
            cnt <= cnt + 1;
            if (cnt >= WAIT)
            begin
                ext_rd_done <= !nack_en;
                ext_rd_nack <= nack_en;
                ext_rd_data <= mem[ext_rd_addr[1:0]];
                cnt <= 0;
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/status_gpio_irq_reset_ctrl_tb.sv ***
// Self-checking bench for the status, pin and start-up block
`timescale 1ns/1ps
`default_nettype none
`include "status_gpio_defines.svh"

module status_gpio_irq_reset_ctrl_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic master_reset_n = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pll_locked = 1'b1;
    logic sync_busy = 1'b0;
    logic holdover_alarm = 1'b0;
    logic [1:0] loss_of_signal = 2'h0;
    logic [3:0] gpio_in = 4'h0;
    logic mem_nack = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, ref_select_in, irq_out_n, config_done, ext_rd_req;
    logic ext_rd_done, ext_rd_nack;
    logic [3:0] gpio_out, gpio_oe, clk_out_enable;
    logic [7:0] ext_rd_addr, ext_rd_data;
    logic [32:0] exp_q [$];
    logic [32:0] e;
    int err_count = 0;
    int cmp_count = 0;
    int n;
    logic [31:0] r;

    status_gpio_irq_reset_ctrl i_dut (.pclk(pclk), .presetn(presetn), .master_reset_n(master_reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pll_locked(pll_locked), .sync_busy(sync_busy),
        .holdover_alarm(holdover_alarm), .loss_of_signal(loss_of_signal), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .ref_select_in(ref_select_in),
        .clk_out_enable(clk_out_enable), .irq_out_n(irq_out_n), .config_done(config_done),
        .ext_rd_req(ext_rd_req), .ext_rd_addr(ext_rd_addr), .ext_rd_done(ext_rd_done),
        .ext_rd_nack(ext_rd_nack), .ext_rd_data(ext_rd_data));

    ext_mem_model i_mem (.pclk(pclk), .nack_en(mem_nack), .ext_rd_req(ext_rd_req), .ext_rd_addr(ext_rd_addr),
        .ext_rd_done(ext_rd_done), .ext_rd_nack(ext_rd_nack), .ext_rd_data(ext_rd_data));

    // Clock
    always #2.5 pclk = ~pclk;

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic cmp(input string nm, input logic [32:0] ex, input logic [32:0] got);
        cmp_count++;
        if (got !== ex)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // APB transfer; a read notes its expected {pslverr, prdata}
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr)
            exp_q.push_back({1'b0, d});
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge pclk);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Read monitor: takes the oldest note when an answer appears
    always @(posedge pclk)
    begin
        if (pready === 1'b1 && !(presetn && master_reset_n))
            cmp("pready_in_reset", 33'h0, 33'h1);
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            e = exp_q.pop_front();
            cmp("read", e, {pslverr, prdata});
        end
    end

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge pclk);
        err_count++;
        give_verdict();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(32'h6B09));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        n = 0;
        do begin settle(1); n++; end while (config_done !== 1'b1);
        cmp("config_edges", 33'h1, {32'h0, n >= 21 && n <= 23});
        $display("test startup done");
        // Map select picks the enable mask
        for (int k = 0; k < 4; k++)
        begin
            gpio_in <= k[3:0];
            settle(6);
            cmp("clk_out_enable", (`OTP_OE_MAP >> (4 * k)) & 33'hF, clk_out_enable);
        end
        gpio_in <= 4'h4;
        settle(4);
        cmp("ref_select_in", 33'h1, ref_select_in);
        apb(1'b1, `REG_OUT_CTRL, 32'hF1);
        settle(6);
        cmp("clk_out_enable_pd", 33'h0E, clk_out_enable);
        $display("test output enable done");
        // Sticky flags and interrupt
        apb(1'b1, `REG_IRQ_EN, 32'hF);
        holdover_alarm <= 1'b1;
        settle(6);
        cmp("irq_out_n", 33'h0, irq_out_n);
        apb(1'b1, `REG_STATUS, 32'h2);
        apb(1'b0, `REG_STATUS, 32'h212);
        holdover_alarm <= 1'b0;
        settle(4);
        apb(1'b0, `REG_STATUS, 32'h12);
        apb(1'b1, `REG_STATUS, 32'h2);
        apb(1'b1, `REG_IRQ_EN, 32'h0);
        loss_of_signal <= 2'h1;
        settle(6);
        cmp("irq_masked", 33'h1, irq_out_n);
        apb(1'b0, `REG_STATUS, 32'h404);
        loss_of_signal <= 2'h0;
        settle(4);
        apb(1'b1, `REG_STATUS, 32'h4);
        apb(1'b0, `REG_STATUS, 32'h0);
        $display("test flags done");
        // Fixed-function outputs, then register-driven outputs
        apb(1'b1, `REG_IRQ_EN, 32'hF);
        apb(1'b1, `REG_CTRL, 32'h4FF);
        for (int k = 0; k < 4; k++)
        begin
            r = $urandom;
            pll_locked <= ~r[3];
            loss_of_signal <= r[2:1];
            holdover_alarm <= r[0];
            settle(6);
            cmp("gpio_out_fixed", {29'h0, r[3], r[1], r[2], r[0]}, gpio_out);
            cmp("gpio_oe", 33'hF, gpio_oe);
        end
        pll_locked <= 1'b1;
        holdover_alarm <= 1'b0;
        loss_of_signal <= 2'h0;
        sync_busy <= 1'b1;
        apb(1'b1, `REG_CTRL, 32'h5FF);
        settle(6);
        cmp("lol_wait_sync", 33'h1, gpio_out[3]);
        sync_busy <= 1'b0;
        settle(6);
        cmp("lol_after_sync", 33'h0, gpio_out[3]);
        apb(1'b1, `REG_CTRL, 32'h40F);
        apb(1'b1, `REG_GPO, r);
        settle(3);
        cmp("gpio_out_reg", {29'h0, r[3:0]}, gpio_out);
        $display("test pins done");
        // Master reset mid-run, one read issued while held; boot read refused this time
        master_reset_n <= 1'b0;
        mem_nack <= 1'b1;
        settle(2);
        cmp("reset_outputs", 33'h1, {24'h0, clk_out_enable, gpio_oe, irq_out_n});
        fork
            apb(1'b0, `REG_CTRL, `OTP_CTRL);
            begin settle(4); master_reset_n <= 1'b1; end
        join
        apb(1'b0, `REG_IRQ_EN, 32'h0);
        apb(1'b0, `REG_OUT_CTRL, `OTP_OUT_CTRL);
        apb(1'b0, `REG_OE_MAP, `OTP_OE_MAP);
        apb(1'b0, `REG_GPO, `OTP_GPO);
        apb(1'b0, `REG_BOOT, 32'hD);
        apb(1'b0, `REG_STATUS, 32'h20);
        apb(1'b0, `REG_GPI, 32'h4);
        apb(1'b1, `REG_GPO, 32'h5);
        apb(1'b0, `REG_GPO, 32'h5);
        exp_q.push_back({1'b1, 32'h0});
        apb(1'b1, 8'h20, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        exp_q.delete(exp_q.size() - 1);
        $display("test reset done");
        settle(2);
        give_verdict();
    end
endmodule
`default_nettype wire
